// *** verilog/mbx_pkg.sv ***
// Purpose : Shared constants and carriers of the reader/host mailbox.
// Assumes : One 100 MHz clock; reader frames arrive already decoded.
// Notes   : Overview list below.
//
// Overview of operation
// - Extended mode maps blocks FCh..FFh onto buffer.
// - Frames with reception errors are dropped silently.
// - Good mailbox write is acknowledged without host.
// - Only reader or host owns buffer at once.
// - Buffer kept while powered; cleared when field returns.
// - Write to FCh sets writing flag, rx start.
// - Write to FFh raises rx end, message waiting.
// - FFh before FCh is a protocol error.
// - Unread message: further reader writes get error.
// - Host reads from offset 10h, then clears buffer.
// - Read of FCh returns flags in fourth word.
// - Reader writes FFh after reading; tx end raised.
// - Before transmit FCh reads zero, host pending set.
// - Extended mode reads allowed only at block FCh.
// - Sixteen bytes in, twelve plus flags byte out.
// - Host update during reader write refused, access error.
// - Interleaved memory write succeeds, buffer is discarded.
// - Status flags are readable at any time.
// - Memory writes and mailbox accesses served without mode change.
// - Tunneling plus extended enabled means tunneling wins.
////////////////////////////////////////////////////////////////////////////////
package mbx_pkg;

  localparam logic [7:0] MBX_BLK_FIRST = 8'hFC;
  localparam logic [7:0] MBX_BLK_SECOND = 8'hFD;
  localparam logic [7:0] MBX_BLK_THIRD = 8'hFE;
  localparam logic [7:0] MBX_BLK_LAST = 8'hFF;

  // Register byte addresses on the host bus
  localparam logic [7:0] MBX_OFS_CTRL = 8'h00;
  localparam logic [7:0] MBX_OFS_STATUS = 8'h04;
  localparam logic [7:0] MBX_OFS_CMD = 8'h08;
  localparam logic [7:0] MBX_OFS_EVENT = 8'h0C;
  localparam logic [7:0] MBX_OFS_BUF0 = 8'h10;
  localparam logic [7:0] MBX_OFS_BUF3 = 8'h1C;

  // Control and command bits
  localparam int MBX_CTRL_EXT = 0;
  localparam int MBX_CTRL_TUN = 1;
  localparam int MBX_CMD_CLEAR = 0;
  localparam int MBX_CMD_TX = 1;
  localparam logic [1:0] MBX_CTRL_RST = 2'h0;

  // Flags byte, also the low byte of the status register
  localparam int MBX_FLG_OUT_READY = 0;
  localparam int MBX_FLG_HOST_PEND = 1;
  localparam int MBX_FLG_IN_WAIT = 2;
  localparam int MBX_FLG_RADIO_WR = 3;

  // Sticky event bits, write one to clear
  localparam int MBX_EV_RX_START = 0;
  localparam int MBX_EV_RX_END = 1;
  localparam int MBX_EV_TX_END = 2;
  localparam int MBX_EV_ACC_ERR = 3;
  localparam int MBX_EV_PROTO_ERR = 4;
  localparam int MBX_EV_W = 5;
  localparam logic [MBX_EV_W-1:0] MBX_EV_RST = 5'h00;

  localparam logic [1:0] MBX_RESP_OKAY = 2'h0;
  localparam logic [1:0] MBX_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MBX_ST_IDLE = 4'b0001,
    MBX_ST_RX   = 4'b0010,
    MBX_ST_FULL = 4'b0100,
    MBX_ST_TX   = 4'b1000
  } mbx_state_t;

  typedef enum logic [2:0] {
    MBX_RSP_SILENT = 3'h0,
    MBX_RSP_ACK    = 3'h1,
    MBX_RSP_ERROR  = 3'h2,
    MBX_RSP_DATA   = 3'h3,
    MBX_RSP_MEMORY = 3'h4
  } mbx_rsp_kind_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        rx_error;
    logic [7:0]  block;
    logic [31:0] data;
  } mbx_rf_cmd_t;

  typedef struct packed {
    logic          valid;
    mbx_rsp_kind_t kind;
    logic [127:0]  data;
  } mbx_rf_rsp_t;

endpackage

// *** verilog/mbx_sync2.sv ***
// Purpose : Two-stage level synchroniser.
// Assumes : Input is asynchronous to aclk.
// Notes   : First stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module mbx_sync2 (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic d_async,
  output logic      q
);
  logic meta_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d_async;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** verilog/mbx_axil_slave.sv ***
// Purpose : AXI4-Lite slave front end giving one-cycle access strobes.
// Assumes : Decode and read data come back in the strobe cycle.
// Notes   : One write and one read in flight at most.
`timescale 1ns/100ps
`default_nettype none
module mbx_axil_slave
  import mbx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic             rd_stb,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  typedef struct packed {
    logic        aw_h;
    logic        w_h;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mbx_axil_st_t;

  mbx_axil_st_t s_r, s_nxt;

  assign wr_stb  = s_r.aw_h & s_r.w_h & ~s_r.bvalid;
  assign wr_addr = s_r.addr;
  assign wr_data = s_r.data;
  assign wr_strb = s_r.strb;
  assign rd_stb  = arvalid & s_r.arready;

  always_comb begin
    s_nxt = s_r;
    if (awvalid && s_r.awready) begin
      s_nxt.aw_h = 1'b1;
      s_nxt.addr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_h  = 1'b1;
      s_nxt.data = wdata;
      s_nxt.strb = wstrb;
    end
    if (wr_stb) begin
      s_nxt.aw_h   = 1'b0;
      s_nxt.w_h    = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = wr_ok ? MBX_RESP_OKAY : MBX_RESP_SLVERR;
    end else if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (rd_stb) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_data;
      s_nxt.rresp  = rd_ok ? MBX_RESP_OKAY : MBX_RESP_SLVERR;
    end else if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.awready = ~s_nxt.aw_h & ~s_nxt.bvalid;
    s_nxt.wready  = ~s_nxt.w_h & ~s_nxt.bvalid;
    s_nxt.arready = ~s_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready  = s_r.wready;
  assign bvalid  = s_r.bvalid;
  assign bresp   = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid  = s_r.rvalid;
  assign rdata   = s_r.rdata;
  assign rresp   = s_r.rresp;
endmodule
`default_nettype wire

// *** verilog/mbx_mailbox.sv ***
// Purpose : Mailbox between a contactless reader and a host processor.
// Assumes : Reader frames are decoded upstream on aclk; field pin is async.
// Notes   : Host reaches control, status, events and buffer over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module mbx_mailbox
  import mbx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire mbx_rf_cmd_t rf_cmd,
  output mbx_rf_rsp_t      rf_rsp,
  input  wire logic        rf_field_pin
);
  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [3:0][31:0]     buf_w;
    mbx_state_t           phase;
    logic                 ext_mod;
    logic                 tun_mod;
    logic [MBX_EV_W-1:0]  events;
    logic                 field_prev;
    mbx_rf_rsp_t          rsp;
  } mbx_st_t;

  mbx_st_t s_r, s_nxt;

  logic        field_s;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic        rd_stb;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic [7:0]  flags;
  logic        ext_active;
  logic        rd_buf;
  logic        wr_buf;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_buf_addr(input logic [7:0] a);
    return (a >= MBX_OFS_BUF0) && (a <= MBX_OFS_BUF3) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [1:0] buf_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - MBX_OFS_BUF0;
    return d[3:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules

  mbx_sync2 u_field_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d_async (rf_field_pin),
    .q       (field_s)
  );

  mbx_axil_slave u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_stb  (rd_stb),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Flags and mode

  // Tunneling takes precedence, so the mailbox goes quiet
  assign ext_active = s_r.ext_mod & ~s_r.tun_mod;

  // Fixed flag layout
  always_comb begin
    flags = 8'h00;
    flags[MBX_FLG_OUT_READY] = (s_r.phase == MBX_ST_TX);
    // Host still owes outbound data until it transmits
    flags[MBX_FLG_HOST_PEND] = (s_r.phase != MBX_ST_TX);
    flags[MBX_FLG_IN_WAIT]   = (s_r.phase == MBX_ST_FULL);
    flags[MBX_FLG_RADIO_WR]  = (s_r.phase == MBX_ST_RX);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host read decode

  assign rd_buf = is_buf_addr(s_axi_araddr);
  assign wr_buf = is_buf_addr(wr_addr);

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (rd_buf) begin
      // Reader owns the buffer mid-message
      if (s_r.phase != MBX_ST_RX) begin
        rd_data = s_r.buf_w[buf_index(s_axi_araddr)];
      end
    end else begin
      unique case (s_axi_araddr)
        MBX_OFS_CTRL: begin
          rd_data[MBX_CTRL_EXT] = s_r.ext_mod;
          rd_data[MBX_CTRL_TUN] = s_r.tun_mod;
        end
        MBX_OFS_STATUS: rd_data = {24'h00_0000, flags};
        MBX_OFS_CMD:    rd_data = 32'h0000_0000;
        MBX_OFS_EVENT:  rd_data = {27'h000_0000, s_r.events};
        default:        rd_ok = 1'b0;
      endcase
    end
  end

  // Status takes writes and ignores them, so a sweep over the map sees no error
  always_comb begin
    wr_ok = wr_buf || (wr_addr == MBX_OFS_CTRL) || (wr_addr == MBX_OFS_CMD) ||
            (wr_addr == MBX_OFS_EVENT) || (wr_addr == MBX_OFS_STATUS);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [MBX_EV_W-1:0] ev_set;
    logic [MBX_EV_W-1:0] ev_clr;
    logic                host_blocked;
    ev_set       = '0;
    ev_clr       = '0;
    host_blocked = (s_r.phase == MBX_ST_RX);
    s_nxt        = s_r;
    s_nxt.rsp.valid = 1'b0;
    s_nxt.field_prev = field_s;

    //////////////////////////////////////////////////////////////////////////
    // Host side
    if (rd_stb && rd_buf && host_blocked) begin
      ev_set[MBX_EV_ACC_ERR] = 1'b1;
    end

    if (wr_stb) begin
      if (wr_buf) begin
        if (host_blocked) begin
          ev_set[MBX_EV_ACC_ERR] = 1'b1;
        end else if (buf_index(wr_addr) != 2'd3) begin
          // Fourth word carries flags toward the reader, so it stays host read-only
          s_nxt.buf_w[buf_index(wr_addr)] =
            byte_merge(s_r.buf_w[buf_index(wr_addr)], wr_data, wr_strb);
        end
      end else begin
        unique case (wr_addr)
          MBX_OFS_CTRL: begin
            if (wr_strb[0]) begin
              s_nxt.ext_mod = wr_data[MBX_CTRL_EXT];
              s_nxt.tun_mod = wr_data[MBX_CTRL_TUN];
            end
          end
          MBX_OFS_CMD: begin
            if (wr_strb[0] && wr_data[MBX_CMD_CLEAR]) begin
              if (host_blocked) begin
                ev_set[MBX_EV_ACC_ERR] = 1'b1;
              end else begin
                // Drops the waiting message and reopens reception
                s_nxt.buf_w = '0;
                s_nxt.phase = MBX_ST_IDLE;
              end
            end else if (wr_strb[0] && wr_data[MBX_CMD_TX]) begin
              if (host_blocked || s_r.phase == MBX_ST_FULL) begin
                ev_set[MBX_EV_ACC_ERR] = 1'b1;
              end else begin
                s_nxt.phase = MBX_ST_TX;
              end
            end
          end
          MBX_OFS_EVENT: ev_clr = wr_data[MBX_EV_W-1:0];
          default: ;
        endcase
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Reader side
    // Evaluated after the host side: a frame in the same cycle as a host command
    // decides the phase, and the host sees the outcome on its next access
    if (rf_cmd.valid) begin
      s_nxt.rsp.valid = 1'b1;
      s_nxt.rsp.kind  = MBX_RSP_MEMORY;
      s_nxt.rsp.data  = '0;
      if (rf_cmd.rx_error) begin
        s_nxt.rsp.kind = MBX_RSP_SILENT;
      end else if (!ext_active) begin
        s_nxt.rsp.kind = MBX_RSP_MEMORY;
      end else if (!rf_cmd.write) begin
        if (rf_cmd.block == MBX_BLK_FIRST) begin
          s_nxt.rsp.kind = MBX_RSP_DATA;
          // Data only once transmitted, else zeros
          if (s_r.phase == MBX_ST_TX) begin
            s_nxt.rsp.data[127:32] = {s_r.buf_w[2], s_r.buf_w[1], s_r.buf_w[0]};
          end
          // Flags in the last byte of the fourth word
          s_nxt.rsp.data[31:0] = {24'h00_0000, flags};
        end else begin
          s_nxt.rsp.kind = MBX_RSP_ERROR;
          ev_set[MBX_EV_PROTO_ERR] = 1'b1;
        end
      end else if (rf_cmd.block < MBX_BLK_FIRST) begin
        // Memory write completes; half-received message is lost
        s_nxt.rsp.kind = MBX_RSP_MEMORY;
        if (s_r.phase == MBX_ST_RX) begin
          s_nxt.buf_w = '0;
          s_nxt.phase = MBX_ST_IDLE;
        end
      end else begin
        s_nxt.rsp.kind = MBX_RSP_ACK;
        unique case (s_r.phase)
          MBX_ST_IDLE, MBX_ST_RX: begin
            if (rf_cmd.block == MBX_BLK_FIRST) begin
              s_nxt.buf_w[0] = rf_cmd.data;
              s_nxt.phase    = MBX_ST_RX;
              ev_set[MBX_EV_RX_START] = 1'b1;
            end else if (s_r.phase == MBX_ST_IDLE) begin
              s_nxt.rsp.kind = MBX_RSP_ERROR;
              ev_set[MBX_EV_PROTO_ERR] = 1'b1;
            end else if (rf_cmd.block == MBX_BLK_LAST) begin
              s_nxt.buf_w[3] = rf_cmd.data;
              s_nxt.phase    = MBX_ST_FULL;
              ev_set[MBX_EV_RX_END] = 1'b1;
            end else if (rf_cmd.block == MBX_BLK_SECOND) begin
              s_nxt.buf_w[1] = rf_cmd.data;
            end else begin
              s_nxt.buf_w[2] = rf_cmd.data;
            end
          end
          MBX_ST_FULL: begin
            s_nxt.rsp.kind = MBX_RSP_ERROR;
            ev_set[MBX_EV_PROTO_ERR] = 1'b1;
          end
          MBX_ST_TX: begin
            if (rf_cmd.block == MBX_BLK_LAST) begin
              // Reader hands the buffer back
              s_nxt.buf_w = '0;
              s_nxt.phase = MBX_ST_IDLE;
              ev_set[MBX_EV_TX_END] = 1'b1;
            end else begin
              s_nxt.rsp.kind = MBX_RSP_ERROR;
              ev_set[MBX_EV_PROTO_ERR] = 1'b1;
            end
          end
          default: begin
            s_nxt.phase = MBX_ST_IDLE;
          end
        endcase
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Field returns after loss: buffer and handshake start over
    if (field_s && !s_r.field_prev) begin
      s_nxt.buf_w = '0;
      s_nxt.phase = MBX_ST_IDLE;
    end

    // A new event wins over a clear in the same cycle
    s_nxt.events = (s_r.events & ~ev_clr) | ev_set;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  // Field edge detector resets low: a field already present at release counts
  // as a return and clears the buffer once, harmless since it is empty then
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r            <= '0;
      s_r.phase      <= MBX_ST_IDLE;
      s_r.ext_mod    <= MBX_CTRL_RST[MBX_CTRL_EXT];
      s_r.tun_mod    <= MBX_CTRL_RST[MBX_CTRL_TUN];
      s_r.events     <= MBX_EV_RST;
      s_r.rsp.kind   <= MBX_RSP_SILENT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rf_rsp = s_r.rsp;
endmodule
`default_nettype wire

// *** tb/mbx_mailbox_monitor.sv ***
// Purpose : Port checks on the reader/host mailbox.
// Assumes : One clock; aresetn synchronous, active low.
// Notes   : Mode bits are internal, so frame checks also accept the memory path.
`timescale 1ns/100ps
`default_nettype none
module mbx_mailbox_monitor
  import mbx_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire mbx_rf_cmd_t rf_cmd,
  input wire mbx_rf_rsp_t rf_rsp
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic go;
  assign go = rf_cmd.valid && !rf_cmd.rx_error;
  ////////////////////////////////////////////////////////////////////////////////
  a_rsp_follows_cmd: assert property (rf_cmd.valid |=> rf_rsp.valid)
    else $error("reader answer missing");
  a_rsp_no_spare: assert property (!rf_cmd.valid |=> !rf_rsp.valid)
    else $error("reader answer without command");
  a_bad_frame_silent: assert property (rf_cmd.valid && rf_cmd.rx_error
    |=> rf_rsp.kind == MBX_RSP_SILENT) else $error("bad frame answered");
  a_read_only_fc: assert property (go && !rf_cmd.write
    && rf_cmd.block != MBX_BLK_FIRST
    |=> rf_rsp.kind inside {MBX_RSP_ERROR, MBX_RSP_MEMORY}) else $error("read off first block");
  a_read_fc_data: assert property (go && !rf_cmd.write
    && rf_cmd.block == MBX_BLK_FIRST
    |=> rf_rsp.kind inside {MBX_RSP_DATA, MBX_RSP_MEMORY}) else $error("first block read kind");
  a_low_write_mem: assert property (go && rf_cmd.write
    && rf_cmd.block < MBX_BLK_FIRST
    |=> rf_rsp.kind == MBX_RSP_MEMORY) else $error("memory write not passed on");
  a_mbx_write_kind: assert property (go && rf_cmd.write
    && rf_cmd.block >= MBX_BLK_FIRST
    |=> rf_rsp.kind inside {MBX_RSP_ACK, MBX_RSP_ERROR, MBX_RSP_MEMORY})
    else $error("mailbox write kind");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  c_ack: cover property (rf_rsp.valid && rf_rsp.kind == MBX_RSP_ACK);
  c_data: cover property (rf_rsp.valid && rf_rsp.kind == MBX_RSP_DATA);
  c_error: cover property (rf_rsp.valid && rf_rsp.kind == MBX_RSP_ERROR);
endmodule
bind mbx_mailbox mbx_mailbox_monitor u_mon (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .rf_cmd, .rf_rsp);
`default_nettype wire

// *** tb/mbx_reader_model.sv ***
// Purpose : Behavioural contactless reader with field control.
// Assumes : Frames arrive decoded; one command in flight.
// Notes   : Idle payload is inverted so a stale frame never looks fresh.
`timescale 1ns/100ps
`default_nettype none
module mbx_reader_model
  import mbx_pkg::*;
(
  input  wire logic        aclk,
  output var mbx_rf_cmd_t  rf_cmd,
  input  wire mbx_rf_rsp_t rf_rsp,
  output var logic         field
);
  mbx_rsp_kind_t kind;
  logic [127:0]  data;
  logic          seen;
  initial begin
    rf_cmd = '0;
    field = 1'b0;
  end
  task set_field(input logic v);
    @(posedge aclk);
    field <= v;
  endtask
  task xfer(input logic w, input logic e, input logic [7:0] b, input logic [31:0] d);
    int n;
    seen = 1'b0;
    @(posedge aclk);
    rf_cmd <= '{valid: 1'b1, write: w, rx_error: e, block: b, data: d};
    @(posedge aclk);
    rf_cmd <= '{valid: 1'b0, write: ~w, rx_error: ~e, block: ~b, data: ~d};
    for (n = 0; n < 8 && !seen; n++) begin
      @(posedge aclk);
      seen = (rf_rsp.valid === 1'b1);
    end
    kind = rf_rsp.kind;
    data = rf_rsp.data;
  endtask
endmodule
`default_nettype wire

// *** tb/mbx_mailbox_tb_top.sv ***
// Purpose : Self-checking bench for the reader/host mailbox.
// Assumes : Host speaks AXI4-Lite; reader model drives frames.
// Notes   : Ready is raised late on purpose to exercise response hold.
`timescale 1ns/100ps
`default_nettype none
module mbx_mailbox_tb_top;
  import mbx_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, rf_field_pin;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  mbx_rf_cmd_t rf_cmd;
  mbx_rf_rsp_t rf_rsp;
  int          error_cnt = 0, num_checks = 0, i;
  mbx_mailbox DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rf_cmd, .rf_rsp, .rf_field_pin);
  mbx_reader_model u_rdr (.aclk, .rf_cmd, .rf_rsp, .field(rf_field_pin));
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  task results;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input string n, input logic [127:0] e, input logic [127:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s exp %0h got %0h", n, e, g);
    end
  endtask
  task wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 128'({n < 20, er}), 128'({1'b1, s_axi_bresp}));
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    chk("read", 128'({n < 20, er, e}), 128'({1'b1, s_axi_rresp, s_axi_rdata}));
  endtask
  task rfc(input logic w, input logic e, input logic [7:0] b, input logic [31:0] d,
           input mbx_rsp_kind_t ek);
    u_rdr.xfer(w, e, b, d);
    chk("rsp kind", 128'({1'b1, ek}), 128'({u_rdr.seen, u_rdr.kind}));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    u_rdr.set_field(1'b1);
    repeat (6) @(posedge aclk);
    rdc(MBX_OFS_CTRL, 32'h0, MBX_RESP_OKAY);
    rdc(8'h20, 32'h0, MBX_RESP_SLVERR);
    wrc(8'h20, 32'h0, MBX_RESP_SLVERR);
    rfc(1, 0, MBX_BLK_FIRST, 32'h1, MBX_RSP_MEMORY);
    wrc(MBX_OFS_CTRL, 32'h3, MBX_RESP_OKAY);
    rdc(MBX_OFS_CTRL, 32'h3, MBX_RESP_OKAY);
    rfc(1, 0, MBX_BLK_FIRST, 32'h1, MBX_RSP_MEMORY);
    wrc(MBX_OFS_CTRL, 32'h1, MBX_RESP_OKAY);
    rfc(1, 0, MBX_BLK_LAST, 32'h1, MBX_RSP_ERROR);
    rdc(MBX_OFS_EVENT, 32'h10, MBX_RESP_OKAY);
    rfc(1, 1, MBX_BLK_FIRST, 32'h1, MBX_RSP_SILENT);
    rdc(MBX_OFS_STATUS, 32'h2, MBX_RESP_OKAY);
    rfc(0, 0, MBX_BLK_SECOND, 32'h0, MBX_RSP_ERROR);
    rfc(0, 0, 8'h10, 32'h0, MBX_RSP_ERROR);
    wrc(MBX_OFS_EVENT, 32'h1F, MBX_RESP_OKAY);
    // Inbound message, host pokes the buffer while the reader owns it
    rfc(1, 0, MBX_BLK_FIRST, 32'hA0, MBX_RSP_ACK);
    rdc(MBX_OFS_STATUS, 32'hA, MBX_RESP_OKAY);
    wrc(MBX_OFS_BUF0, 32'h5, MBX_RESP_OKAY);
    rdc(MBX_OFS_BUF0, 32'h0, MBX_RESP_OKAY);
    rdc(MBX_OFS_EVENT, 32'h9, MBX_RESP_OKAY);
    for (i = 1; i < 4; i++)
      rfc(1, 0, MBX_BLK_FIRST + 8'(i), 32'hA0 + 32'(i), MBX_RSP_ACK);
    rdc(MBX_OFS_STATUS, 32'h6, MBX_RESP_OKAY);
    rdc(MBX_OFS_EVENT, 32'hB, MBX_RESP_OKAY);
    rfc(1, 0, MBX_BLK_FIRST, 32'hEE, MBX_RSP_ERROR);
    for (i = 0; i < 4; i++)
      rdc(MBX_OFS_BUF0 + 8'(4 * i), 32'hA0 + 32'(i), MBX_RESP_OKAY);
    rfc(0, 0, MBX_BLK_FIRST, 32'h0, MBX_RSP_DATA);
    chk("flags", 128'h6, u_rdr.data);
    wrc(MBX_OFS_CMD, 32'h1, MBX_RESP_OKAY);
    rdc(MBX_OFS_STATUS, 32'h2, MBX_RESP_OKAY);
    // Reader breaks the empty-buffer rule: memory write wins, buffer is lost
    rfc(1, 0, MBX_BLK_FIRST, 32'h1, MBX_RSP_ACK);
    rfc(1, 0, 8'h10, 32'h1, MBX_RSP_MEMORY);
    rdc(MBX_OFS_STATUS, 32'h2, MBX_RESP_OKAY);
    rfc(1, 0, MBX_BLK_LAST, 32'h1, MBX_RSP_ERROR);
    // Outbound message
    wrc(MBX_OFS_EVENT, 32'h1F, MBX_RESP_OKAY);
    rfc(0, 0, MBX_BLK_FIRST, 32'h0, MBX_RSP_DATA);
    chk("poll", 128'h2, u_rdr.data);
    for (i = 0; i < 3; i++)
      wrc(MBX_OFS_BUF0 + 8'(4 * i), 32'hC0 + 32'(i), MBX_RESP_OKAY);
    wrc(MBX_OFS_CMD, 32'h2, MBX_RESP_OKAY);
    rdc(MBX_OFS_STATUS, 32'h1, MBX_RESP_OKAY);
    rfc(0, 0, MBX_BLK_FIRST, 32'h0, MBX_RSP_DATA);
    chk("out", {32'hC2, 32'hC1, 32'hC0, 32'h1}, u_rdr.data);
    rfc(1, 0, MBX_BLK_LAST, 32'h0, MBX_RSP_ACK);
    rdc(MBX_OFS_EVENT, 32'h4, MBX_RESP_OKAY);
    rdc(MBX_OFS_BUF0, 32'h0, MBX_RESP_OKAY);
    // Buffer survives a field gap, cleared when the field returns
    wrc(MBX_OFS_BUF0, 32'h77, MBX_RESP_OKAY);
    u_rdr.set_field(1'b0);
    repeat (6) @(posedge aclk);
    rdc(MBX_OFS_BUF0, 32'h77, MBX_RESP_OKAY);
    u_rdr.set_field(1'b1);
    repeat (6) @(posedge aclk);
    rdc(MBX_OFS_BUF0, 32'h0, MBX_RESP_OKAY);
    results();
  end
endmodule
`default_nettype wire
